/* File: verilog/pgc_top.sv */
// test frame generator and crc frame checker with axi4-lite registers
// Behaviour
// - burst zero continuous, else exactly that many
// - enable code picks copper, sgmii or rgmii
// - trigger valid: enable, self-clear, burst nonzero
// - trigger reads one done, zero transmitting
// - writing zero while one restarts burst
// - trigger writes ignored while transmitting
// - self-clear zero clears enable after burst
// - self-clear one keeps enable after burst
// - payload pseudo-random or 5a/a5 pattern
// - length select gives 64 or 1518 bytes
// - error bit sends bad crc and symbol error
// - saturating eight-bit received packet counter
// - saturating eight-bit crc error counter
// - counter reset clears both, self-clears
// - source code off, copper, sgmii or rgmii
// - gap is programmed value plus one byte
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
module pgc_top
    import pgc_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output logic [7:0] gen_data,
    output logic gen_copper_valid,
    output logic gen_sgmii_valid,
    output logic gen_rgmii_valid,
    output logic gen_symbol_error,
    input wire logic [7:0] rx_copper_data,
    input wire logic rx_copper_valid,
    input wire logic rx_copper_error,
    input wire logic [7:0] rx_sgmii_data,
    input wire logic rx_sgmii_valid,
    input wire logic rx_sgmii_error,
    input wire logic [7:0] rx_rgmii_data,
    input wire logic rx_rgmii_valid,
    input wire logic rx_rgmii_error
);
    // register state
    logic [7:0] burst;
    logic [2:0] gen_en;
    logic trig_done;
    logic self_clr;
    logic pay_sel;
    logic len_sel;
    logic err_inj;
    logic [2:0] chk_src;
    logic cnt_clr;
    logic [7:0] gap_len;
    logic [7:0] pkt_cnt;
    logic [7:0] crc_err_cnt;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;

    // bus slave state
    logic aw_held;
    logic w_held;
    logic [5:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic [15:0] wr_val;
    logic [15:0] gen_ctrl_rd;
    logic [15:0] rd_word;
    logic rd_hit;
    logic wr_hit;

    // generator state
    pgc_state_t state;
    logic [10:0] byte_idx;
    logic [7:0] gap_cnt;
    logic [7:0] sent_cnt;
    logic [31:0] tx_crc;
    logic [15:0] prbs;
    logic pat_phase;
    logic [10:0] frame_len;
    logic [10:0] pay_len;
    logic [7:0] cur_byte;
    logic [31:0] fcs;
    logic [1:0] fcs_sel;
    logic trig_valid;
    logic wr_gen;
    logic start;
    logic frame_last;
    logic burst_end;
    logic ev_done;
    logic [2:0] tx_port;

    // checker state
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_error;
    logic rx_valid_d;
    logic [31:0] rx_crc;
    logic rx_bad;
    logic [31:0] rx_crc_next;
    logic rx_end;
    logic rx_end_bad;
    logic chk_clear;

    // write channel: address and data are taken in either order
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_idx <= 6'h00;
        end
        else if (s_axi_awvalid && !aw_held)
        begin
            aw_held <= 1'b1;
            aw_idx <= s_axi_awaddr[7:2];
        end
        else if (wr_fire)
        begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid && !w_held)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (wr_fire)
        begin
            w_held <= 1'b0;
        end
    end

    assign wr_hit = aw_idx inside {PGC_IDX_GEN_CTRL, PGC_IDX_RX_COUNTS,
                                   PGC_IDX_CHK_CTRL, PGC_IDX_GAP,
                                   PGC_IDX_IRQ_STATUS, PGC_IDX_IRQ_MASK};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PGC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? PGC_RESP_OKAY : PGC_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // byte lanes merge into the current value of the addressed register
    always_comb
    begin
        wr_val = rd_word;
        if (w_strb[0])
        begin
            wr_val[7:0] = w_data[7:0];
        end
        if (w_strb[1])
        begin
            wr_val[15:8] = w_data[15:8];
        end
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid && !wr_fire;
    assign gen_ctrl_rd = {burst, gen_en, trig_done, self_clr, pay_sel,
                          len_sel, err_inj};

    always_comb
    begin
        rd_hit = 1'b1;
        case (wr_fire ? aw_idx : s_axi_araddr[7:2])
            PGC_IDX_GEN_CTRL: rd_word = gen_ctrl_rd;
            PGC_IDX_RX_COUNTS: rd_word = {pkt_cnt, crc_err_cnt};
            PGC_IDX_CHK_CTRL: rd_word = {11'h000, cnt_clr, 1'b0, chk_src};
            PGC_IDX_GAP: rd_word = {8'h00, gap_len};
            PGC_IDX_IRQ_STATUS: rd_word = {13'h0000, irq_status};
            PGC_IDX_IRQ_MASK: rd_word = {13'h0000, irq_mask};
            default:
            begin
                rd_word = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // a read waits one cycle while a write fires, so rd_word is shared
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= PGC_RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid && !wr_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_word};
            s_axi_rresp <= rd_hit ? PGC_RESP_OKAY : PGC_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // generator control decode
    assign wr_gen = wr_fire && aw_idx == PGC_IDX_GEN_CTRL;
    assign trig_valid = gen_en != PGC_PORT_OFF && self_clr &&
                        burst != 8'h00;
    // a fresh enable or a restart from the done state begins a burst
    assign start = wr_gen && pgc_port_ok(wr_val[PGC_GEN_EN_LSB +: 3]) &&
                   (state == PGC_ST_IDLE) &&
                   (gen_en == PGC_PORT_OFF || (trig_valid && trig_done &&
                    !wr_val[PGC_GEN_TRIG_BIT]));
    assign frame_last = state == PGC_ST_FRAME && byte_idx == frame_len - 11'h1;
    assign burst_end = frame_last && burst != 8'h00 &&
                       sent_cnt + 8'h01 == burst;
    assign ev_done = burst_end;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            burst <= PGC_GEN_CTRL_RST[15:8];
            gen_en <= PGC_GEN_CTRL_RST[7:5];
            self_clr <= PGC_GEN_CTRL_RST[PGC_GEN_SELFCLR_BIT];
            pay_sel <= PGC_GEN_CTRL_RST[PGC_GEN_PAYLOAD_BIT];
            len_sel <= PGC_GEN_CTRL_RST[PGC_GEN_LEN_BIT];
            err_inj <= PGC_GEN_CTRL_RST[PGC_GEN_ERR_BIT];
        end
        else
        begin
            if (wr_gen)
            begin
                burst <= wr_val[PGC_GEN_BURST_LSB +: 8];
                gen_en <= wr_val[PGC_GEN_EN_LSB +: 3];
                self_clr <= wr_val[PGC_GEN_SELFCLR_BIT];
                pay_sel <= wr_val[PGC_GEN_PAYLOAD_BIT];
                len_sel <= wr_val[PGC_GEN_LEN_BIT];
                err_inj <= wr_val[PGC_GEN_ERR_BIT];
            end
            else if (burst_end && !self_clr)
            begin
                gen_en <= PGC_PORT_OFF;
            end
            // self_clr high: gen_en is left as written
        end
    end

    // trigger bit is status only; software writes never store it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trig_done <= PGC_GEN_CTRL_RST[PGC_GEN_TRIG_BIT];
        end
        else if (start)
        begin
            trig_done <= 1'b0;
        end
        else if (burst_end)
        begin
            trig_done <= 1'b1;
        end
    end

    // frame sequencer
    assign frame_len = len_sel ? PGC_LEN_LONG : PGC_LEN_SHORT;
    assign pay_len = frame_len - PGC_FCS_BYTES;
    assign fcs_sel = 2'(byte_idx - pay_len);
    // a flipped fcs bit makes the crc bad on purpose
    assign fcs = ~tx_crc ^ {31'h00000000, err_inj};

    always_comb
    begin
        if (byte_idx < pay_len)
        begin
            cur_byte = pay_sel ? (pat_phase ? PGC_PAT_B : PGC_PAT_A)
                               : prbs[7:0];
        end
        else
        begin
            cur_byte = fcs[8*fcs_sel +: 8];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= PGC_ST_IDLE;
            byte_idx <= 11'h000;
            gap_cnt <= 8'h00;
            sent_cnt <= 8'h00;
            tx_port <= PGC_PORT_OFF;
        end
        else
        begin
            case (state)
                PGC_ST_IDLE:
                begin
                    byte_idx <= 11'h000;
                    sent_cnt <= 8'h00;
                    if (start)
                    begin
                        state <= PGC_ST_FRAME;
                        tx_port <= wr_val[PGC_GEN_EN_LSB +: 3];
                    end
                end
                PGC_ST_FRAME:
                begin
                    byte_idx <= byte_idx + 11'h1;
                    if (frame_last)
                    begin
                        byte_idx <= 11'h000;
                        sent_cnt <= sent_cnt + 8'h01;
                        gap_cnt <= gap_len;
                        state <= burst_end ? PGC_ST_IDLE : PGC_ST_GAP;
                    end
                end
                PGC_ST_GAP:
                begin
                    gap_cnt <= gap_cnt - 8'h01;
                    if (gap_cnt == 8'h00)
                    begin
                        tx_port <= gen_en;
                        // clearing the enable ends a continuous run here
                        state <= pgc_port_ok(gen_en) ? PGC_ST_FRAME
                                                      : PGC_ST_IDLE;
                    end
                end
                default:
                begin
                    state <= PGC_ST_IDLE;
                end
            endcase
        end
    end

    // payload sources and transmit crc advance once per payload byte
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_crc <= PGC_CRC_INIT;
            prbs <= PGC_PRBS_SEED;
            pat_phase <= 1'b0;
        end
        else if (state != PGC_ST_FRAME)
        begin
            tx_crc <= PGC_CRC_INIT;
            pat_phase <= 1'b0;
        end
        else if (byte_idx < pay_len)
        begin
            tx_crc <= pgc_crc_byte(tx_crc, cur_byte);
            prbs <= {prbs[14:0], prbs[15] ^ prbs[13] ^ prbs[12] ^ prbs[10]};
            pat_phase <= !pat_phase;
        end
    end

    // registered byte stream toward the chosen interface
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gen_data <= 8'h00;
            gen_copper_valid <= 1'b0;
            gen_sgmii_valid <= 1'b0;
            gen_rgmii_valid <= 1'b0;
            gen_symbol_error <= 1'b0;
        end
        else
        begin
            gen_data <= state == PGC_ST_FRAME ? cur_byte : 8'h00;
            gen_copper_valid <= state == PGC_ST_FRAME &&
                                tx_port == PGC_PORT_COPPER;
            gen_sgmii_valid <= state == PGC_ST_FRAME &&
                               tx_port == PGC_PORT_SGMII;
            gen_rgmii_valid <= state == PGC_ST_FRAME &&
                               tx_port == PGC_PORT_RGMII;
            gen_symbol_error <= state == PGC_ST_FRAME && err_inj &&
                                byte_idx == pay_len;
        end
    end

    // checker control, gap and mask registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            chk_src <= PGC_CHK_SRC_RST;
            cnt_clr <= 1'b0;
            gap_len <= PGC_GAP_RST;
            irq_mask <= PGC_IRQ_MASK_RST;
        end
        else
        begin
            cnt_clr <= 1'b0;
            if (wr_fire && aw_idx == PGC_IDX_CHK_CTRL)
            begin
                chk_src <= wr_val[2:0];
                cnt_clr <= wr_val[PGC_CHK_CLR_BIT];
            end
            if (wr_fire && aw_idx == PGC_IDX_GAP)
            begin
                gap_len <= wr_val[7:0];
            end
            if (wr_fire && aw_idx == PGC_IDX_IRQ_MASK)
            begin
                irq_mask <= wr_val[2:0];
            end
        end
    end

    // checker source select; reserved codes see an idle line
    always_comb
    begin
        case (chk_src)
            PGC_PORT_COPPER:
            begin
                rx_data = rx_copper_data;
                rx_valid = rx_copper_valid;
                rx_error = rx_copper_error;
            end
            PGC_PORT_SGMII:
            begin
                rx_data = rx_sgmii_data;
                rx_valid = rx_sgmii_valid;
                rx_error = rx_sgmii_error;
            end
            PGC_PORT_RGMII:
            begin
                rx_data = rx_rgmii_data;
                rx_valid = rx_rgmii_valid;
                rx_error = rx_rgmii_error;
            end
            default:
            begin
                rx_data = 8'h00;
                rx_valid = 1'b0;
                rx_error = 1'b0;
            end
        endcase
    end

    assign rx_crc_next = pgc_crc_byte(rx_valid_d ? rx_crc : PGC_CRC_INIT,
                                      rx_data);
    assign rx_end = rx_valid_d && !rx_valid;
    assign rx_end_bad = rx_end && (rx_bad || rx_crc != PGC_CRC_RESIDUE);
    // source off holds the checker in reset
    assign chk_clear = chk_src == PGC_PORT_OFF || cnt_clr;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_valid_d <= 1'b0;
            rx_crc <= PGC_CRC_INIT;
            rx_bad <= 1'b0;
        end
        else
        begin
            rx_valid_d <= rx_valid;
            if (rx_valid)
            begin
                rx_crc <= rx_crc_next;
                rx_bad <= (rx_valid_d && rx_bad) || rx_error;
            end
        end
    end

    // counters stop at all ones rather than wrapping
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pkt_cnt <= 8'h00;
            crc_err_cnt <= 8'h00;
        end
        else if (chk_clear)
        begin
            pkt_cnt <= 8'h00;
            crc_err_cnt <= 8'h00;
        end
        else
        begin
            if (rx_end && pkt_cnt != 8'hff)
            begin
                pkt_cnt <= pkt_cnt + 8'h01;
            end
            if (rx_end_bad && crc_err_cnt != 8'hff)
            begin
                crc_err_cnt <= crc_err_cnt + 8'h01;
            end
        end
    end

    // sticky events: a new event beats a write-one-to-clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status <= 3'h0;
        end
        else
        begin
            irq_status <= (irq_status & ~((wr_fire &&
                          aw_idx == PGC_IDX_IRQ_STATUS) ? wr_val[2:0] : 3'h0))
                          | {rx_end_bad && !chk_clear, rx_end && !chk_clear,
                             ev_done};
        end
    end

    assign irq = |(irq_status & irq_mask);
endmodule : pgc_top

/* File: verilog/pgc_pkg.sv */
// shared constants for the packet generator and frame checker
package pgc_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] PGC_IDX_GEN_CTRL = 6'h10;
    localparam logic [5:0] PGC_IDX_RX_COUNTS = 6'h11;
    localparam logic [5:0] PGC_IDX_CHK_CTRL = 6'h12;
    localparam logic [5:0] PGC_IDX_GAP = 6'h13;
    localparam logic [5:0] PGC_IDX_IRQ_STATUS = 6'h14;
    localparam logic [5:0] PGC_IDX_IRQ_MASK = 6'h15;
    // generator control fields
    localparam int PGC_GEN_BURST_LSB = 8;
    localparam int PGC_GEN_EN_LSB = 5;
    localparam int PGC_GEN_TRIG_BIT = 4;
    localparam int PGC_GEN_SELFCLR_BIT = 3;
    localparam int PGC_GEN_PAYLOAD_BIT = 2;
    localparam int PGC_GEN_LEN_BIT = 1;
    localparam int PGC_GEN_ERR_BIT = 0;
    localparam int PGC_CHK_CLR_BIT = 4;
    // interface codes shared by generator enable and checker source
    localparam logic [2:0] PGC_PORT_OFF = 3'h0;
    localparam logic [2:0] PGC_PORT_COPPER = 3'h2;
    localparam logic [2:0] PGC_PORT_SGMII = 3'h4;
    localparam logic [2:0] PGC_PORT_RGMII = 3'h6;
    // reset values
    localparam logic [15:0] PGC_GEN_CTRL_RST = 16'h0000;
    localparam logic [2:0] PGC_CHK_SRC_RST = 3'h0;
    localparam logic [7:0] PGC_GAP_RST = 8'h0c;
    localparam logic [2:0] PGC_IRQ_MASK_RST = 3'h0;
    // frame lengths in bytes, frame check sequence included
    localparam logic [10:0] PGC_LEN_SHORT = 11'h040;
    localparam logic [10:0] PGC_LEN_LONG = 11'h5ee;
    localparam logic [10:0] PGC_FCS_BYTES = 11'h004;
    localparam logic [7:0] PGC_PAT_A = 8'h5a;
    localparam logic [7:0] PGC_PAT_B = 8'ha5;
    localparam logic [15:0] PGC_PRBS_SEED = 16'hace1;
    localparam logic [31:0] PGC_CRC_INIT = 32'hffffffff;
    localparam logic [31:0] PGC_CRC_POLY = 32'hedb88320;
    localparam logic [31:0] PGC_CRC_RESIDUE = 32'hdebb20e3;
    localparam logic [1:0] PGC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PGC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PGC_ST_IDLE = 3'b001,
        PGC_ST_FRAME = 3'b010,
        PGC_ST_GAP = 3'b100
    } pgc_state_t;

    // reflected crc-32, one byte, no final inversion
    function automatic logic [31:0] pgc_crc_byte(input logic [31:0] crc,
                                                 input logic [7:0] data);
        logic [31:0] c;
        c = crc ^ {24'h000000, data};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ PGC_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : pgc_crc_byte

    function automatic logic pgc_port_ok(input logic [2:0] code);
        return code == PGC_PORT_COPPER || code == PGC_PORT_SGMII ||
               code == PGC_PORT_RGMII;
    endfunction : pgc_port_ok
endpackage : pgc_pkg

/* File: tb/pgc_top_props.sv */
// checker for the generator stream and register bus handshakes
`timescale 1ns/10ps
module pgc_top_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [7:0] gen_data,
    input wire logic gen_copper_valid,
    input wire logic gen_sgmii_valid,
    input wire logic gen_rgmii_valid,
    input wire logic gen_symbol_error
);
    logic v;
    logic [10:0] len;
    assign v = gen_copper_valid | gen_sgmii_valid | gen_rgmii_valid;
    // bytes of the frame in flight
    always_ff @(posedge aclk)
    begin
        len <= (v && aresetn) ? len + 11'h001 : 11'h000;
    end
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_one_port: assert property (
        $onehot0({gen_copper_valid, gen_sgmii_valid, gen_rgmii_valid}))
        else $error("more than one generator port active");
    chk_idle_data: assert property (!v |-> gen_data == 8'h00)
        else $error("generator data not zero outside a frame");
    chk_frame_len: assert property (
        $fell(v) |-> len == 11'h040 || len == 11'h5ee)
        else $error("generated frame length wrong");
    chk_gap_min: assert property ($fell(v) |-> !v [*8])
        else $error("inter-frame gap too short");
    chk_sym_pulse: assert property (
        gen_symbol_error |-> v ##1 !gen_symbol_error)
        else $error("symbol error not a pulse inside a frame");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered on the next edge");
    chk_read_release: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held after it was taken");
    chk_write_release: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after it was taken");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    cover property ($rose(gen_sgmii_valid));
    cover property (gen_symbol_error);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : pgc_top_props

bind pgc_top pgc_top_props i_props (.*);

/* File: tb/pgc_link_model.sv */
// link partner that loops every generated frame back to the checker
`timescale 1ns/10ps
module pgc_link_model (
    input wire logic aclk,
    input wire logic [7:0] gen_data,
    input wire logic gen_copper_valid,
    input wire logic gen_sgmii_valid,
    input wire logic gen_rgmii_valid,
    input wire logic gen_symbol_error,
    output logic [7:0] rx_copper_data,
    output logic rx_copper_valid,
    output logic rx_copper_error,
    output logic [7:0] rx_sgmii_data,
    output logic rx_sgmii_valid,
    output logic rx_sgmii_error,
    output logic [7:0] rx_rgmii_data,
    output logic rx_rgmii_valid,
    output logic rx_rgmii_error
);
    initial
    begin
        {rx_copper_data, rx_sgmii_data, rx_rgmii_data} = 24'h000000;
        {rx_copper_valid, rx_sgmii_valid, rx_rgmii_valid} = 3'h0;
        {rx_copper_error, rx_sgmii_error, rx_rgmii_error} = 3'h0;
    end
    // an idle data line toggles so a stale byte can never look valid
    always @(posedge aclk)
    begin
        rx_copper_valid <= gen_copper_valid;
        rx_copper_data <= gen_copper_valid ? gen_data : ~rx_copper_data;
        rx_copper_error <= gen_copper_valid & gen_symbol_error;
        rx_sgmii_valid <= gen_sgmii_valid;
        rx_sgmii_data <= gen_sgmii_valid ? gen_data : ~rx_sgmii_data;
        rx_sgmii_error <= gen_sgmii_valid & gen_symbol_error;
        rx_rgmii_valid <= gen_rgmii_valid;
        rx_rgmii_data <= gen_rgmii_valid ? gen_data : ~rx_rgmii_data;
        rx_rgmii_error <= gen_rgmii_valid & gen_symbol_error;
    end
endmodule : pgc_link_model

/* File: tb/pgc_top_tb.sv */
// self-checking bench for the packet generator and frame checker
`timescale 1ns/10ps
module pgc_top_tb
    import pgc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, gen_symbol_error, pv = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdat;
    logic [7:0] gen_data, fb, rx_copper_data, rx_sgmii_data, rx_rgmii_data;
    logic gen_copper_valid, gen_sgmii_valid, gen_rgmii_valid;
    logic rx_copper_valid, rx_sgmii_valid, rx_rgmii_valid;
    logic rx_copper_error, rx_sgmii_error, rx_rgmii_error;
    int err_count = 0, n_tests = 0, nfr = 0, n0;
    wire v = gen_copper_valid | gen_sgmii_valid | gen_rgmii_valid;

    pgc_top i_dut (.*);
    pgc_link_model i_link (.*);

    initial
    begin
        forever #20 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        pv <= v;
        if (v && !pv)
        begin
            nfr <= nfr + 1;
            fb <= gen_data;
        end
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            resp = s_axi_bresp;
            if (s_axi_bvalid)
                s_axi_bready <= 1'b0;
        end while (s_axi_bready);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                {resp, rdat} = {s_axi_rresp, s_axi_rdata};
            if (s_axi_rvalid)
                s_axi_rready <= 1'b0;
        end while (s_axi_rready);
    endtask : rd

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rdat, e);
    endtask : rc

    // let checker counts settle
    task automatic wait_done;
        for (int n = 0; n < 3000; n++)
        begin
            rd(8'h40);
            if (rdat[4] === 1'b1)
                break;
        end
        chk(rdat[4], 1'b1);
        repeat (4) @(posedge aclk);
    endtask : wait_done

    task automatic t_regs;
        rc(8'h40, 32'h0);
        rc(8'h44, 32'h0);
        rc(8'h48, 32'h0);
        rc(8'h4c, 32'h0c);
        rc(8'h7c, 32'h0);
        chk(resp, PGC_RESP_SLVERR);
        wr(8'h7c, 32'h1);
        chk(resp, PGC_RESP_SLVERR);
    endtask : t_regs

    task automatic t_burst;
        n0 = nfr;
        wr(8'h48, 32'h2);
        chk(resp, PGC_RESP_OKAY);
        wr(8'h40, 32'h0344);
        wait_done;
        chk(nfr - n0, 3);
        chk(fb, PGC_PAT_A);
        rc(8'h40, 32'h0314);
        rc(8'h44, 32'h0300);
    endtask : t_burst

    task automatic t_trig;
        n0 = nfr;
        wr(8'h48, 32'h14);
        rc(8'h44, 32'h0);
        rc(8'h48, 32'h4);
        wr(8'h40, 32'h028b);
        rd(8'h40);
        chk(rdat[4], 1'b0);
        wr(8'h40, 32'h029b);
        wait_done;
        rc(8'h40, 32'h029b);
        rc(8'h44, 32'h0202);
        wr(8'h40, 32'h028b);
        rd(8'h40);
        chk(rdat[4], 1'b0);
        wait_done;
        chk(nfr - n0, 4);
        rc(8'h44, 32'h0404);
    endtask : t_trig

    task automatic t_cont;
        wr(8'h48, 32'h16);
        n0 = nfr;
        wr(8'h40, 32'h00c0);
        repeat (400) @(posedge aclk);
        wr(8'h40, 32'h0);
        repeat (200) @(posedge aclk);
        chk(nfr - n0 >= 4, 1'b1);
        rc(8'h44, (nfr - n0) << 8);
        chk(irq, 1'b0);
        wr(8'h54, 32'h2);
        chk(irq, 1'b1);
        wr(8'h50, 32'h7);
        rc(8'h50, 32'h0);
        chk(irq, 1'b0);
        n0 = nfr;
        wr(8'h40, 32'h01e0);
        repeat (100) @(posedge aclk);
        chk(nfr - n0, 0);
        wr(8'h48, 32'h0);
        rc(8'h44, 32'h0);
    endtask : t_cont

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_burst;
        t_trig;
        t_cont;
        print_verdict;
    end

    initial
    begin
        repeat (40000) @(posedge aclk);
        err_count++;
        print_verdict;
    end
endmodule : pgc_top_tb
